/* pcp_consts.svh */
// Constants of the paged configuration port host controller
// What this block does
// - Every transaction is one 24-bit frame: 16-bit address part, 8 data bits.
// - Frame select held low during a frame; input sampled on rising serial clock.
// - Host keeps the serial clock at or below 2 MHz.
// - Bank bit: 0 analog bank, 1 serial-link bank.
// - Access-kind bit: 0 page selection, 1 register access.
// - Lane bit sends a serial-link access to channel A (0) or B (1).
// - Analog page chosen by writing 0011h: 80h master, 0Fh converter page.
// - Readback: read bit set to 1, address sent, data returned on readback pin.
// - Link page select: bank 1, kind 0, 00h to 4003h then high byte to 4004h.
// - High page byte 68h main digital, 69h digital link, next code analog link.
// - Writes into a selected link page set both bank and kind bits to 1.
// - Writing 01h to 4005h enables per-channel link addressing; reset 00h.
`ifndef PCP_CONSTS_SVH
`define PCP_CONSTS_SVH

`define PCP_FRAME_BITS      24
`define PCP_HDR_BITS        4
`define PCP_ADDR_BITS       12
`define PCP_DATA_BITS       8
`define PCP_HDR_RW_POS      3
`define PCP_HDR_BANK_POS    2
`define PCP_HDR_KIND_POS    1
`define PCP_HDR_LANE_POS    0

`define PCP_CLK_KHZ         250000
`define PCP_SCLK_MAX_KHZ    2000
`define PCP_SCLK_HALF_CYC   ((`PCP_CLK_KHZ + 2 * `PCP_SCLK_MAX_KHZ - 1) / (2 * `PCP_SCLK_MAX_KHZ))

`define PCP_ADDR_PAGE_ANALOG 12'h011
`define PCP_PAGE_MASTER      8'h80
`define PCP_PAGE_CONVERTER   8'h0F
`define PCP_ADDR_LINK_PG_LO  12'h003
`define PCP_ADDR_LINK_PG_HI  12'h004
`define PCP_ADDR_LINK_SPLIT  12'h005
`define PCP_LINK_PG_LO_VAL   8'h00
`define PCP_LINK_PG_MAIN     8'h68
`define PCP_LINK_PG_DIGITAL  8'h69
`define PCP_LINK_PG_ANALOG   8'h6A
`define PCP_LINK_SPLIT_ON    8'h01

`define PCP_REG_SET1_CONV    12'h020
`define PCP_REG_SET1_BUF     12'h021
`define PCP_REG_SET2_CONV    12'h023
`define PCP_REG_SET2_BUF     12'h024
`define PCP_REG_SLEEP_CTRL   12'h026
`define PCP_REG_TREF_GATE    12'h053
`define PCP_REG_PART_GATE    12'h055
`define PCP_FULL_SLEEP_POS   7
`define PCP_PIN_BYPASS_POS   6
`define PCP_SET_CHOICE_POS   5
`define PCP_PART_ENABLE_POS  4
`define PCP_OVL_LEVEL_RESET  8'hE3

`endif

/* pcp_pkg.sv */
// Types of the paged configuration port host controller
package pcp_pkg;
  typedef enum logic [2:0] {
    PCP_IDLE  = 3'b000,
    PCP_SETUP = 3'b001,
    PCP_LOW   = 3'b011,
    PCP_HIGH  = 3'b010,
    PCP_HOLD  = 3'b110,
    PCP_GAP   = 3'b100
  } pcp_state_e;
endpackage : pcp_pkg

/* pcp_host.sv */
// Host controller driving the paged configuration serial port
`timescale 1ns/10ps
`default_nettype none
`include "pcp_consts.svh"

module pcp_host
  import pcp_pkg::*;
#(
  parameter int HALF_CYC = `PCP_SCLK_HALF_CYC
) (
  input  wire logic        clk,
  input  wire logic        reset_n,
  input  wire logic        clk_en,
  input  wire logic        cmd_valid,
  output logic             cmd_ready,
  input  wire logic        cmd_read,
  input  wire logic        cmd_bank,
  input  wire logic        cmd_kind,
  input  wire logic        cmd_lane,
  input  wire logic [11:0] cmd_addr,
  input  wire logic [7:0]  cmd_data,
  output logic             rsp_valid,
  output logic [7:0]       rsp_data,
  input  wire logic        sleep_req,
  output logic             overload_seen,
  output logic             frame_select_low,
  output logic             serial_clk,
  output logic             serial_in,
  input  wire logic        serial_readback_out,
  output logic             sleep_pin,
  input  wire logic        fast_overload_flag
);

  generate
    if (HALF_CYC < 4 || HALF_CYC > 65535) begin : g_bad_half
      $error("HALF_CYC out of range");
    end
  endgenerate

  // Frame layout lives in the constants header; refuse one that no longer adds up
  generate
    if (`PCP_HDR_BITS + `PCP_ADDR_BITS + `PCP_DATA_BITS != `PCP_FRAME_BITS) begin : g_bad_frame
      $error("Frame fields do not fill the frame");
    end
    if (`PCP_ADDR_BITS != 12 || `PCP_DATA_BITS != 8 || `PCP_HDR_BITS != 4) begin : g_bad_fields
      $error("Field widths differ from the command ports");
    end
  endgenerate

  pcp_state_e  state_r;
  logic [15:0] tick_r;
  logic [4:0]  bit_r;
  logic [23:0] shift_out_r;
  logic [7:0]  shift_in_r;
  logic        read_r;
  logic        rb_meta_r;
  logic        rb_sync_r;
  logic        ovl_meta_r;
  logic        ovl_sync_r;
  logic        tick_done;
  logic [3:0]  hdr_bits;
  logic [23:0] frame_nxt;

  localparam logic [15:0] HALF_M1 = 16'(HALF_CYC - 1);
  localparam logic [4:0]  LAST_BIT = 5'(`PCP_FRAME_BITS - 1);
  localparam logic [4:0]  DATA_FIRST = 5'(`PCP_HDR_BITS + `PCP_ADDR_BITS);

  assign tick_done = (tick_r == HALF_M1);

  // Page selects and split mode travel as ordinary frames; the host only lays out fields
  always_comb begin
    hdr_bits                    = 4'h0;
    hdr_bits[`PCP_HDR_RW_POS]   = cmd_read;
    hdr_bits[`PCP_HDR_BANK_POS] = cmd_bank;
    hdr_bits[`PCP_HDR_KIND_POS] = cmd_kind;
    hdr_bits[`PCP_HDR_LANE_POS] = cmd_lane;
    frame_nxt                   = {hdr_bits, cmd_addr, cmd_data};
  end

  // Readback pin is asynchronous to clk
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rb_meta_r <= 1'b0;
      rb_sync_r <= 1'b0;
    end else if (clk_en) begin
      rb_meta_r <= serial_readback_out;
      rb_sync_r <= rb_meta_r;
    end
  end

  // Overload pin, when repurposed by the device, watched as a level
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ovl_meta_r    <= 1'b0;
      ovl_sync_r    <= 1'b0;
      overload_seen <= 1'b0;
    end else if (clk_en) begin
      ovl_meta_r    <= fast_overload_flag;
      ovl_sync_r    <= ovl_meta_r;
      overload_seen <= ovl_sync_r;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      sleep_pin <= 1'b0;
    end else if (clk_en) begin
      sleep_pin <= sleep_req;
    end
  end

  // Every phase lasts one half period so the clock never exceeds its limit
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      tick_r <= 16'h0000;
    end else if (clk_en) begin
      if (state_r == PCP_IDLE || tick_done) begin
        tick_r <= 16'h0000;
      end else begin
        tick_r <= tick_r + 16'h0001;
      end
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_r <= PCP_IDLE;
      bit_r   <= 5'h00;
    end else if (clk_en) begin
      case (state_r)
        PCP_IDLE: begin
          if (cmd_valid && cmd_ready) begin
            state_r <= PCP_SETUP;
          end
        end
        PCP_SETUP: begin
          if (tick_done) begin
            state_r <= PCP_HIGH;
            bit_r   <= 5'h00;
          end
        end
        PCP_LOW: begin
          if (tick_done) begin
            state_r <= PCP_HIGH;
          end
        end
        PCP_HIGH: begin
          if (tick_done) begin
            if (bit_r == LAST_BIT) begin
              state_r <= PCP_HOLD;
            end else begin
              state_r <= PCP_LOW;
              bit_r   <= bit_r + 5'h01;
            end
          end
        end
        PCP_HOLD: begin
          if (tick_done) begin
            state_r <= PCP_GAP;
          end
        end
        PCP_GAP: begin
          if (tick_done) begin
            state_r <= PCP_IDLE;
          end
        end
        default: begin
          state_r <= PCP_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cmd_ready <= 1'b0;
    end else if (clk_en) begin
      cmd_ready <= (state_r == PCP_IDLE) && !(cmd_valid && cmd_ready);
    end
  end

  // Pins: select low for the whole frame, clock idles low
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      frame_select_low <= 1'b1;
      serial_clk       <= 1'b0;
      serial_in        <= 1'b0;
      shift_out_r      <= 24'h000000;
      read_r           <= 1'b0;
    end else if (clk_en) begin
      if (state_r == PCP_IDLE && cmd_valid && cmd_ready) begin
        shift_out_r      <= frame_nxt;
        serial_in        <= frame_nxt[23];
        read_r           <= cmd_read;
        frame_select_low <= 1'b0;
      end
      if (tick_done) begin
        case (state_r)
          PCP_SETUP, PCP_LOW: begin
            serial_clk <= 1'b1;
          end
          PCP_HIGH: begin
            serial_clk <= 1'b0;
            if (bit_r != LAST_BIT) begin
              // Change data on falling edge, half a period before the sampling edge
              shift_out_r <= {shift_out_r[22:0], 1'b0};
              serial_in   <= shift_out_r[22];
            end
          end
          PCP_HOLD: begin
            frame_select_low <= 1'b1;
            serial_in        <= 1'b0;
          end
          default: begin
            serial_clk <= 1'b0;
          end
        endcase
      end
    end
  end

  // Readback bits sampled at end of each high phase of the data field
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      shift_in_r <= 8'h00;
      rsp_valid  <= 1'b0;
      rsp_data   <= 8'h00;
    end else if (clk_en) begin
      rsp_valid <= 1'b0;
      // Only the data phase is kept, so a floating line during the header cannot leak in
      if (state_r == PCP_HIGH && tick_done && bit_r >= DATA_FIRST) begin
        shift_in_r <= {shift_in_r[6:0], rb_sync_r};
      end
      if (state_r == PCP_HOLD && tick_done && read_r) begin
        rsp_valid <= 1'b1;
        rsp_data  <= shift_in_r;
      end
    end
  end

endmodule : pcp_host
`default_nettype wire

/* pcp_host_chk.sv */
// Port checker for the configuration port host
`timescale 1ns/10ps
`default_nettype none
module pcp_host_chk (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic clk_en,
  input wire logic cmd_valid,
  input wire logic cmd_ready,
  input wire logic cmd_read,
  input wire logic rsp_valid,
  input wire logic sleep_req,
  input wire logic overload_seen,
  input wire logic frame_select_low,
  input wire logic serial_clk,
  input wire logic serial_in,
  input wire logic sleep_pin,
  input wire logic fast_overload_flag
);
  logic [4:0] rise_r;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) rise_r <= 5'h00;
    else if ($rose(serial_clk)) rise_r <= rise_r + 5'h01;
    else if (frame_select_low) rise_r <= 5'h00;
  end
  idle_clock_a: assert property (frame_select_low |-> !serial_clk)
    else $error("clock outside frame");
  accept_frame_a: assert property (cmd_valid && cmd_ready && clk_en |=> !cmd_ready && !frame_select_low)
    else $error("frame not started");
  bit_count_a: assert property ($rose(frame_select_low) |-> rise_r == 5'h18)
    else $error("frame length wrong");
  select_setup_a: assert property ($fell(frame_select_low) |-> !serial_clk [*2])
    else $error("no select setup");
  header_first_a: assert property ($fell(frame_select_low) |-> serial_in == $past(cmd_read))
    else $error("first bit wrong");
  data_hold_a: assert property (serial_clk |-> $stable(serial_in))
    else $error("data moved while high");
  answer_after_a: assert property ($rose(rsp_valid) |-> $rose(frame_select_low))
    else $error("stray answer");
  overload_sync_a: assert property ($rose(fast_overload_flag) |-> ##[1:4] overload_seen)
    else $error("overload lost");
  sleep_follow_a: assert property ($rose(sleep_req) |=> sleep_pin)
    else $error("sleep pin late");
  cover property (rsp_valid);
  cover property (overload_seen);
  cover property (sleep_pin);
endmodule : pcp_host_chk
bind pcp_host pcp_host_chk pcp_host_chk_i (.clk, .reset_n, .clk_en, .cmd_valid, .cmd_ready, .cmd_read, .rsp_valid,
  .sleep_req, .overload_seen, .frame_select_low, .serial_clk, .serial_in, .sleep_pin, .fast_overload_flag);
`default_nettype wire

/* pcp_dev_model.sv */
// Behavioural converter on the configuration port
`timescale 1ns/10ps
`default_nettype none
module pcp_dev_model (
  input  wire logic serial_clk,
  input  wire logic frame_select_low,
  input  wire logic serial_in,
  output logic      serial_readback_out
);
  logic [23:0] sh_r = 24'h000000;
  logic [4:0]  cnt_r = 5'h00;
  logic [7:0]  ap_r = 8'h80;
  logic [7:0]  lp_r = 8'h68;
  logic [6:0]  rv_r;
  logic [7:0]  mem [8192];
  // Pages fold on low nibble: brief, enough for the codes used
  function automatic logic [12:0] key(input logic b, input logic [11:0] a);
    return {b, b ? lp_r[3:0] : ap_r[3:0], a[7:0]};
  endfunction : key
  initial foreach (mem[i]) mem[i] = 8'h00;
  always @(posedge serial_clk or posedge frame_select_low) begin
    if (!frame_select_low) begin
      sh_r <= {sh_r[22:0], serial_in};
      cnt_r <= cnt_r + 5'h01;
    end else begin
      cnt_r <= 5'h00;
      // Lane bit ignored: link writes land for both channels
      if (cnt_r == 5'h18 && !sh_r[23]) begin
        if (sh_r[21]) mem[key(sh_r[22], sh_r[19:8])] <= sh_r[7:0];
        else if (sh_r[22] && sh_r[19:8] == 12'h004) lp_r <= sh_r[7:0];
        else if (!sh_r[22] && sh_r[19:8] == 12'h011) ap_r <= sh_r[7:0];
      end
    end
  end
  // Released line flips so a stale bit cannot pass
  always @(negedge serial_clk or posedge frame_select_low) begin
    if (frame_select_low) serial_readback_out <= ~serial_readback_out;
    else if (cnt_r == 5'h10) {serial_readback_out, rv_r} <= mem[key(sh_r[14], sh_r[11:0])];
    else if (cnt_r > 5'h10) {serial_readback_out, rv_r} <= {rv_r, 1'b0};
  end
endmodule : pcp_dev_model
`default_nettype wire

/* pcp_host_tb.sv */
// Bench for the configuration port host
`timescale 1ns/10ps
`default_nettype none
module pcp_host_tb;
  logic        clk = 1'b0, reset_n = 1'b0, cmd_valid = 1'b0, cmd_read = 1'b0, cmd_bank = 1'b0;
  logic        cmd_kind = 1'b0, cmd_lane = 1'b0, sleep_req = 1'b0, fast_overload_flag = 1'b0;
  logic        cmd_ready, rsp_valid, overload_seen, frame_select_low, serial_clk, serial_in;
  logic        serial_readback_out, sleep_pin;
  logic        clk_en = 1'b1, stall_on = 1'b0;
  logic [11:0] cmd_addr = 12'h000;
  logic [7:0]  cmd_data = 8'h00, rsp_data;
  int          err_total = 0, n_tests = 0, cyc = 0;
  logic [11:0] ra [7] = '{12'h020, 12'h021, 12'h023, 12'h024, 12'h026, 12'h053, 12'h055};
  logic [7:0]  rv [7] = '{8'hA5, 8'hC0, 8'h5A, 8'h30, 8'h20, 8'h40, 8'h10};
  pcp_host #(.HALF_CYC(4)) pcp_host_i (.clk, .reset_n, .clk_en, .cmd_valid, .cmd_ready, .cmd_read, .cmd_bank,
    .cmd_kind, .cmd_lane, .cmd_addr, .cmd_data, .rsp_valid, .rsp_data, .sleep_req, .overload_seen,
    .frame_select_low, .serial_clk, .serial_in, .serial_readback_out, .sleep_pin, .fast_overload_flag);
  pcp_dev_model pcp_dev_model_i (.serial_clk, .frame_select_low, .serial_in, .serial_readback_out);
  initial forever #2 clk = ~clk;
  // Periodic freeze while stall_on is set
  always @(negedge clk) clk_en <= !(stall_on && (cyc % 5 == 2));
  task automatic tally_and_finish();
    $display("compares %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : tally_and_finish
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR at %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  // Header is {read, bank, kind, lane}; on reads d is the expected value
  task automatic op(input logic [3:0] h, input logic [11:0] a, input logic [7:0] d);
    @(negedge clk);
    {cmd_read, cmd_bank, cmd_kind, cmd_lane} = h;
    cmd_addr = a;
    cmd_data = d;
    cmd_valid = 1'b1;
    // Held until the select drops, so a frozen accept edge cannot lose it
    while (frame_select_low !== 1'b0) @(negedge clk);
    cmd_valid = 1'b0;
    while (frame_select_low !== 1'b1) @(negedge clk);
    if (h[3]) chk(rsp_data, d);
    if (h[3]) chk({7'h00, rsp_valid}, 8'h01);
  endtask : op
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_total = err_total + 1;
      tally_and_finish();
    end
  end
  initial begin
    repeat (20) @(negedge clk);
    reset_n = 1'b1;
    op(4'h0, 12'h011, 8'h80);
    foreach (ra[i]) op(4'h2, ra[i], rv[i]);
    foreach (ra[i]) op(4'hA, ra[i], rv[i]);
    op(4'h0, 12'h011, 8'h0F);
    op(4'h2, 12'h020, 8'h77);
    op(4'h0, 12'h011, 8'h80);
    op(4'hA, 12'h020, 8'hA5);
    op(4'h4, 12'h003, 8'h00);
    stall_on = 1'b1;
    for (int i = 0; i < 6; i++) begin
      op(4'h4, 12'h004, 8'(8'h68 + i % 3));
      op(i < 3 ? 4'h6 : 4'hE, 12'h010, 8'(8'h68 + i % 3));
    end
    op(4'h4, 12'h005, 8'h01);
    op(4'hF, 12'h010, 8'h6A);
    stall_on = 1'b0;
    repeat (2) @(negedge clk);
    sleep_req = 1'b1;
    // Pin form of the device's trip; the in-stream form needs no host logic
    fast_overload_flag = 1'b1;
    repeat (2) @(negedge clk);
    chk({7'h00, overload_seen}, 8'h00);
    @(negedge clk);
    chk({6'h00, sleep_pin, overload_seen}, 8'h03);
    tally_and_finish();
  end
endmodule : pcp_host_tb
`default_nettype wire
